/* design/lsc_consts.vh */
// Constants for the line status and special command block
// Contract
// - Read-only line-state register at C6
// - Read frame answered with ACK, address, value
// - Bits 0-2: fault, tx amp, rx amp
// - Bit3 undefined, bit4 RF busy, bit5 empty
// - Bit6 ack received, bit7 reads zero
// - Write-only special command register at C7
// - Decode join, write, clear, reload, factory codes
// - Join subcommands: halt, administrator, join
// - Serial join (not administrator) locks out push button
// - Join active blocks writes except halt
// - Halt completes before ACK is sent
// - Key-receive flag picks role at start
// - Successful join copies stored addresses
// - Write key to working or stored copy
// - Working key reloads from stored at reset
// - All-zero key means no key
// - Clear key zeroes selected copy
// - Reload copies stored key to working
// - Factory sequence restores stored defaults
// - Send reset message, then self reset
// - Push button also triggers factory reset
`ifndef LSC_CONSTS_VH
`define LSC_CONSTS_VH
`define LSC_HDR        8'hff
`define LSC_ESC        8'hfe
`define LSC_ESC_OFS    8'h80
`define LSC_ACK        8'h06
`define LSC_NACK       8'h15
`define LSC_ADDR_LINE  8'hc6
`define LSC_ADDR_CMD   8'hc7
`define LSC_OP_JOIN    8'h10
`define LSC_OP_WRITE_KEY   8'h11
`define LSC_OP_CLEAR_KEY  8'h12
`define LSC_OP_RELOAD_KEY  8'h13
`define LSC_OP_FACT    8'h20
`define LSC_FACT_B1    8'haa
`define LSC_FACT_B2    8'hbb
`define LSC_JOIN_HALT  8'h00
`define LSC_JOIN_ADMIN 8'h01
`define LSC_JOIN_PEER  8'h02
`define LSC_SEL_WORK   8'h01
`define LSC_SEL_STORE  8'h02
`define LSC_KEY_LEN    5'd16
`define LSC_MSG_LEN    5'd23
`define LSC_BIT_FAULT  0
`define LSC_BIT_TXAMP  1
`define LSC_BIT_RXAMP  2
`define LSC_BIT_CTS    3
`define LSC_BIT_RF     4
`define LSC_BIT_EMPTY  5
`define LSC_BIT_ACKRX  6
`define LSC_BIT_RSVD   7
`endif

/* design/lsc_core.v */
// Command frame interpreter for the line-state and special command registers
`timescale 1ns/1ns
`include "lsc_consts.vh"
module lsc_core
(
   input  wire         clk,
   input  wire         rst_b,
   input  wire         rx_valid,
   input  wire [7:0]   rx_byte,
   output wire         rx_ready,
   output wire         tx_valid,
   output wire [7:0]   tx_byte,
   input  wire         tx_ready,
   input  wire         fault_occurred_flag,
   input  wire         tx_amp_active,
   input  wire         rx_amp_active,
   input  wire         rf_transfer_active,
   input  wire         uart_buffer_empty,
   input  wire         ack_received,
   input  wire         key_receive_flag,
   input  wire         join_busy,
   input  wire         join_success,
   input  wire         pb_join_req,
   input  wire         pb_factory_req,
   output reg          join_start,
   output reg  [1:0]   join_mode,
   output reg          join_halt,
   output reg          join_as_admin,
   output reg          key_receive_clear,
   output reg          addr_copy,
   output reg          pb_join_go,
   output reg          pb_lock,
   output reg          nv_default_load,
   output reg          self_reset_req,
   output reg  [127:0] working_key,
   output wire         working_key_set,
   output wire         stored_key_set
);
   localparam S_IDLE  = 10'h001;
   localparam S_SIZE  = 10'h002;
   localparam S_MARK  = 10'h004;
   localparam S_KIND  = 10'h008;
   localparam S_RADDR = 10'h010;
   localparam S_DATA  = 10'h020;
   localparam S_EXEC  = 10'h040;
   localparam S_HALT  = 10'h080;
   localparam S_RESP  = 10'h100;
   localparam S_MSG   = 10'h200;
   reg [9:0]   state_r;
   reg [7:0]   rem_r;
   reg         esc_r;
   reg         is_read_r;
   reg [7:0]   addr_r;
   reg [4:0]   idx_r;
   reg [7:0]   cmd_r;
   reg [7:0]   sel_r;
   reg [7:0]   b2_r;
   reg [127:0] key_buf_r;
   reg [127:0] stored_key_r;
   reg [23:0]  resp_r;
   reg [1:0]   resp_cnt_r;
   reg [4:0]   msg_idx_r;
   reg         load_pend_r;
   reg         busy_q_r;
   wire [7:0] line_state;
   wire       take;
   wire       last;
   wire [7:0] dec_byte;
   wire       write_ok;
   assign line_state[`LSC_BIT_FAULT] = fault_occurred_flag;
   assign line_state[`LSC_BIT_TXAMP] = tx_amp_active;
   assign line_state[`LSC_BIT_RXAMP] = rx_amp_active;
   // Undefined bit reads zero so the value is repeatable
   assign line_state[`LSC_BIT_CTS]   = 1'b0;
   assign line_state[`LSC_BIT_RF]    = rf_transfer_active;
   assign line_state[`LSC_BIT_EMPTY] = uart_buffer_empty;
   assign line_state[`LSC_BIT_ACKRX] = ack_received;
   assign line_state[`LSC_BIT_RSVD]  = 1'b0;
   assign rx_ready = (state_r[0] | state_r[1] | state_r[2] | state_r[3] | state_r[4]
                      | state_r[5]);
   assign take     = rx_valid & rx_ready;
   assign last     = (rem_r == 8'h01);
   assign dec_byte = esc_r ? rx_byte + `LSC_ESC_OFS : rx_byte;
   assign tx_valid = state_r[8] | state_r[9];
   assign tx_byte  = resp_r[23:16];

   assign working_key_set = |working_key;
   assign stored_key_set  = |stored_key_r;

   // Halt is never refused, everything else is refused while the join is busy
   assign write_ok = ~join_busy
                     | ((cmd_r == `LSC_OP_JOIN) && (sel_r == `LSC_JOIN_HALT));
   localparam [183:0] RESET_TEXT = "\015\012Configuration Reset\015\012";
   function [7:0] msg_char;
      input [4:0] i;
      msg_char = (i < `LSC_MSG_LEN) ? RESET_TEXT[183 - 8 * i -: 8] : 8'h00;
   endfunction
   // Stored copy has no reset: it models the non-volatile key
   always @(posedge clk)
   begin
      if (state_r[6] && !is_read_r && addr_r == `LSC_ADDR_CMD && write_ok)
      begin
         if (cmd_r == `LSC_OP_WRITE_KEY && sel_r == `LSC_SEL_STORE
             && idx_r == `LSC_KEY_LEN + 5'd2)
            stored_key_r <= key_buf_r;
         else if (cmd_r == `LSC_OP_CLEAR_KEY && sel_r == `LSC_SEL_STORE && idx_r >= 5'd2)
            stored_key_r <= 128'h0;
         else if (cmd_r == `LSC_OP_FACT && idx_r == 5'd3 && sel_r == `LSC_FACT_B1
                  && b2_r == `LSC_FACT_B2)
            stored_key_r <= 128'h0;
      end
      else if (state_r[0] && pb_factory_req && !pb_lock)
         stored_key_r <= 128'h0;
   end

   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_r           <= S_IDLE;
         rem_r             <= 8'h00;
         esc_r             <= 1'b0;
         is_read_r         <= 1'b0;
         addr_r            <= 8'h00;
         idx_r             <= 5'd0;
         cmd_r             <= 8'h00;
         sel_r             <= 8'h00;
         b2_r              <= 8'h00;
         key_buf_r         <= 128'h0;
         resp_r            <= 24'h0;
         resp_cnt_r        <= 2'd0;
         msg_idx_r         <= 5'd0;
         load_pend_r       <= 1'b1;
         busy_q_r          <= 1'b0;
         working_key       <= 128'h0;
         join_start        <= 1'b0;
         join_mode         <= 2'd0;
         join_halt         <= 1'b0;
         join_as_admin     <= 1'b0;
         key_receive_clear <= 1'b0;
         addr_copy         <= 1'b0;
         pb_join_go        <= 1'b0;
         pb_lock           <= 1'b0;
         nv_default_load   <= 1'b0;
         self_reset_req    <= 1'b0;
      end
      else
      begin
         join_start        <= 1'b0;
         join_halt         <= 1'b0;
         key_receive_clear <= 1'b0;
         nv_default_load   <= 1'b0;
         self_reset_req    <= 1'b0;
         busy_q_r          <= join_busy;
         addr_copy         <= join_success;
         pb_join_go        <= pb_join_req & ~pb_lock;
         load_pend_r       <= 1'b0;
         if (load_pend_r)
            working_key <= stored_key_r;
         if (busy_q_r && !join_busy)
            pb_lock <= 1'b0;
         if (take && rx_byte == `LSC_HDR)
         begin
            // Header cannot occur escaped, so it always restarts a frame
            state_r <= S_SIZE;
         end
         else
         begin
            case (state_r)
               S_IDLE:
               begin
                  if (pb_factory_req && !pb_lock)
                  begin
                     nv_default_load <= 1'b1;
                     resp_r[23:16]   <= msg_char(5'd0);
                     msg_idx_r       <= 5'd1;
                     state_r         <= S_MSG;
                  end
               end
               S_SIZE:
               begin
                  if (take)
                  begin
                     rem_r   <= rx_byte;
                     esc_r   <= 1'b0;
                     idx_r   <= 5'd0;
                     state_r <= (rx_byte == 8'h00) ? S_IDLE : S_MARK;
                  end
               end
               S_MARK:
               begin
                  if (take)
                  begin
                     rem_r   <= rem_r - 8'h01;
                     state_r <= (last || rx_byte != `LSC_ESC) ? S_IDLE : S_KIND;
                  end
               end
               S_KIND:
               begin
                  if (take)
                  begin
                     rem_r     <= rem_r - 8'h01;
                     is_read_r <= (rx_byte == `LSC_ESC);
                     addr_r    <= rx_byte + `LSC_ESC_OFS;
                     if (last)
                        state_r <= S_EXEC;
                     else
                        state_r <= (rx_byte == `LSC_ESC) ? S_RADDR : S_DATA;
                  end
               end
               S_RADDR:
               begin
                  if (take)
                  begin
                     rem_r   <= rem_r - 8'h01;
                     addr_r  <= rx_byte + `LSC_ESC_OFS;
                     state_r <= S_EXEC;
                  end
               end
               S_DATA:
               begin
                  if (take)
                  begin
                     rem_r <= rem_r - 8'h01;
                     if (rx_byte == `LSC_ESC && !esc_r)
                        esc_r <= 1'b1;
                     else
                     begin
                        esc_r <= 1'b0;
                        if (idx_r != 5'd31)
                           idx_r <= idx_r + 5'd1;
                        if (idx_r == 5'd0)
                           cmd_r <= dec_byte;
                        else if (idx_r == 5'd1)
                           sel_r <= dec_byte;
                        else
                           key_buf_r <= {key_buf_r[119:0], dec_byte};
                        if (idx_r == 5'd2)
                           b2_r <= dec_byte;
                     end
                     if (last)
                        state_r <= S_EXEC;
                  end
               end
               S_EXEC:
               begin
                  resp_cnt_r <= 2'd0;
                  resp_r     <= {`LSC_NACK, 16'h0};
                  state_r    <= S_RESP;
                  if (is_read_r)
                  begin
                     if (addr_r == `LSC_ADDR_LINE)
                     begin
                        resp_r     <= {`LSC_ACK, `LSC_ADDR_LINE, line_state};
                        resp_cnt_r <= 2'd2;
                     end
                  end
                  else if (addr_r == `LSC_ADDR_CMD && idx_r != 5'd0 && write_ok)
                  begin
                     resp_r <= {`LSC_ACK, 16'h0};
                     case (cmd_r)
                        `LSC_OP_JOIN:
                        begin
                           if (sel_r == `LSC_JOIN_HALT)
                           begin
                              join_halt <= 1'b1;
                              state_r   <= S_HALT;
                           end
                           else if (sel_r == `LSC_JOIN_ADMIN || sel_r == `LSC_JOIN_PEER)
                           begin
                              join_start    <= 1'b1;
                              join_mode     <= sel_r[1:0];
                              join_as_admin <= ~key_receive_flag;
                              if (sel_r == `LSC_JOIN_ADMIN)
                                 key_receive_clear <= 1'b1;
                              else
                                 pb_lock <= 1'b1;
                           end
                        end
                        `LSC_OP_WRITE_KEY:
                           if (sel_r == `LSC_SEL_WORK && idx_r == `LSC_KEY_LEN + 5'd2)
                              working_key <= key_buf_r;
                        `LSC_OP_CLEAR_KEY:
                           if (sel_r == `LSC_SEL_WORK)
                              working_key <= 128'h0;
                        `LSC_OP_RELOAD_KEY:
                           working_key <= stored_key_r;
                        `LSC_OP_FACT:
                           if (idx_r == 5'd3 && sel_r == `LSC_FACT_B1
                               && b2_r == `LSC_FACT_B2)
                           begin
                              nv_default_load <= 1'b1;
                              resp_r[23:16]   <= msg_char(5'd0);
                              msg_idx_r       <= 5'd1;
                              state_r         <= S_MSG;
                           end
                        default:
                           resp_r <= {`LSC_NACK, 16'h0};
                     endcase
                  end
               end
               S_HALT:
               begin
                  // Ack held back until the join engine reports idle
                  if (!join_busy)
                     state_r <= S_RESP;
               end
               S_RESP:
               begin
                  if (tx_ready)
                  begin
                     resp_r     <= {resp_r[15:0], 8'h00};
                     resp_cnt_r <= resp_cnt_r - 2'd1;
                     if (resp_cnt_r == 2'd0)
                        state_r <= S_IDLE;
                  end
               end
               S_MSG:
               begin
                  if (tx_ready)
                  begin
                     resp_r[23:16] <= msg_char(msg_idx_r);
                     msg_idx_r     <= msg_idx_r + 5'd1;
                     if (msg_idx_r == `LSC_MSG_LEN)
                     begin
                        self_reset_req <= 1'b1;
                        state_r        <= S_IDLE;
                     end
                  end
               end
               default:
                  state_r <= S_IDLE;
            endcase
         end
      end
   end
endmodule

/* test/lsc_core_sva.sv */
// Checker for the line status and special command block
`timescale 1ns/1ns
module lsc_core_sva
(
   input wire         clk,
   input wire         rst_b,
   input wire         rx_ready,
   input wire         tx_valid,
   input wire [7:0]   tx_byte,
   input wire         tx_ready,
   input wire         key_receive_flag,
   input wire         join_busy,
   input wire         join_success,
   input wire         pb_join_req,
   input wire         join_start,
   input wire         join_as_admin,
   input wire         addr_copy,
   input wire         pb_join_go,
   input wire         pb_lock,
   input wire         nv_default_load,
   input wire [127:0] working_key,
   input wire         working_key_set
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   addr_copy_a: assert property (join_success |=> addr_copy)
      else $error("address copy missing");
   pb_mask_a: assert property (pb_lock && pb_join_req |=> !pb_join_go)
      else $error("button join not masked");
   pb_origin_a: assert property (pb_join_go |-> $past(pb_join_req))
      else $error("button join without request");
   lock_release_a: assert property ($fell(pb_lock) |-> !$past(join_busy))
      else $error("lock dropped while join busy");
   admin_role_a: assert property (join_start |-> join_as_admin == !$past(key_receive_flag))
      else $error("role not from key flag");
   tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
      else $error("answer byte not held");
   rx_block_a: assert property (tx_valid |-> !rx_ready)
      else $error("bytes taken while answering");
   key_set_a: assert property (working_key_set == (|working_key))
      else $error("key set flag wrong");
   reset_msg_a: assert property (nv_default_load |-> ##[0:8] tx_valid)
      else $error("reset message not started");
   cover property (join_start && pb_lock);
   cover property (nv_default_load);
   cover property (tx_valid && !tx_ready);
endmodule
bind lsc_core lsc_core_sva CHK (.clk(clk), .rst_b(rst_b), .rx_ready(rx_ready),
   .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready),
   .key_receive_flag(key_receive_flag), .join_busy(join_busy),
   .join_success(join_success), .pb_join_req(pb_join_req), .join_start(join_start),
   .join_as_admin(join_as_admin), .addr_copy(addr_copy), .pb_join_go(pb_join_go),
   .pb_lock(pb_lock), .nv_default_load(nv_default_load), .working_key(working_key),
   .working_key_set(working_key_set));

/* test/lsc_core_tb.sv */
// Self-checking bench for the line status and special command block
`timescale 1ns/1ns
module lsc_core_tb;
   logic clk, rst_b, rx_valid, rx_ready, tx_valid, tx_ready;
   logic [7:0] rx_byte, tx_byte;
   logic [5:0] ln;
   logic krf, busy, jsucc, pbj, pbf;
   logic join_start, pb_join_go, nv_default_load, self_reset_req;
   logic [1:0] jmode;
   logic jhalt, krc;
   logic [127:0] working_key;
   logic working_key_set, stored_key_set;
   int err_count, total_checks, n_start, n_pb, n_load, n_rst, n_halt, n_krc;
   lsc_host HOST (.clk(clk), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_ready(rx_ready),
      .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready));
   lsc_core DUT (.clk(clk), .rst_b(rst_b), .rx_valid(rx_valid), .rx_byte(rx_byte),
      .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready),
      .fault_occurred_flag(ln[0]), .tx_amp_active(ln[1]), .rx_amp_active(ln[2]),
      .rf_transfer_active(ln[3]), .uart_buffer_empty(ln[4]), .ack_received(ln[5]),
      .key_receive_flag(krf), .join_busy(busy), .join_success(jsucc), .pb_join_req(pbj),
      .pb_factory_req(pbf), .join_start(join_start), .join_mode(jmode), .join_halt(jhalt),
      .join_as_admin(), .key_receive_clear(krc), .addr_copy(), .pb_join_go(pb_join_go),
      .pb_lock(), .nv_default_load(nv_default_load), .self_reset_req(self_reset_req),
      .working_key(working_key), .working_key_set(working_key_set),
      .stored_key_set(stored_key_set));
   always #4 clk = ~clk;
   always @(posedge clk)
   begin
      n_start += (join_start === 1'b1);
      n_pb    += (pb_join_go === 1'b1);
      n_load  += (nv_default_load === 1'b1);
      n_rst   += (self_reset_req === 1'b1);
      n_halt  += (jhalt === 1'b1);
      n_krc   += (krc === 1'b1);
   end
   function automatic logic [7:0] line_exp(input logic [5:0] v);
      return {1'b0, v[5:3], 1'b0, v[2:0]};
   endfunction
   task automatic chk(input string n, input logic [127:0] e, input logic [127:0] g);
      total_checks++;
      if (g !== e)
      begin
         err_count++;
         $display("ERROR %s expected %h got %h", n, e, g);
      end
   endtask
   task automatic expect_rx(input logic [7:0] e[$]);
      int n;
      n = 0;
      while (HOST.got.size() < e.size() && n < 500)
      begin
         @(posedge clk);
         n++;
      end
      foreach (e[i])
         chk("answer byte", e[i], HOST.got.size() > 0 ? HOST.got.pop_front() : 8'hxx);
      repeat (3) @(posedge clk);
      chk("extra bytes", 0, HOST.got.size());
   endtask
   task automatic complete_run();
      $display("Checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      #(8 * 40000);
      err_count++;
      complete_run();
   end
   initial
   begin
      logic [7:0] k[$];
      logic [7:0] msg[$];
      logic [127:0] kv;
      string s;
      {clk, ln, krf, busy, jsucc, pbj} = '0;
      pbf   = 1'b1; // Clears the unknown stored key before the power-up load
      rst_b = 1'b0;
      void'($urandom(82115));
      @(posedge clk) pbf <= 1'b0;
      repeat (11) @(posedge clk);
      rst_b <= 1'b1;
      for (int t = 0; t < 8; t++)
      begin
         @(posedge clk);
         ln <= (t == 0) ? 6'h3f : 6'($urandom);
         HOST.send({8'hfe, 8'hfe, 8'h46});
         expect_rx({8'h06, 8'hc6, line_exp(ln)});
      end
      HOST.send({8'hfe, 8'hfe, 8'h45});
      expect_rx({8'h15});
      HOST.wr({8'h30});
      expect_rx({8'h15});
      $display("Line state test done");
      repeat (16) k.push_back(8'($urandom));
      k[0] = 8'h80; // Corner: escaped key byte
      kv = {>>{k}};
      HOST.wr({8'h11, 8'h01, k});
      expect_rx({8'h06});
      chk("working key", kv, working_key);
      chk("key set", 1, working_key_set);
      HOST.wr({8'h11, 8'h02, k});
      expect_rx({8'h06});
      HOST.wr({8'h12, 8'h01});
      expect_rx({8'h06});
      chk("cleared key", 0, working_key);
      chk("no key", 0, working_key_set);
      HOST.wr({8'h13});
      expect_rx({8'h06});
      chk("reloaded key", kv, working_key);
      HOST.wr({8'h12, 8'h01});
      expect_rx({8'h06});
      rst_b <= 1'b0;
      @(posedge clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk);
      chk("power-up key", kv, working_key);
      HOST.wr({8'h12, 8'h02});
      expect_rx({8'h06});
      chk("stored key", 0, stored_key_set);
      $display("Key test done");
      for (int m = 0; m < 3; m++)
      begin
         krf <= 1'($urandom);
         HOST.wr({8'h10, 8'(m)});
         expect_rx({8'h06});
      end
      chk("join starts", 2, n_start);
      chk("join mode", 2, jmode);
      chk("halt pulses", 1, n_halt);
      chk("key flag clears", 1, n_krc);
      busy <= 1'b1;
      @(posedge clk) pbj <= 1'b1;
      @(posedge clk) pbj <= 1'b0;
      HOST.wr({8'h12, 8'h01});
      expect_rx({8'h15});
      HOST.wr({8'h10, 8'h00});
      repeat (20) @(posedge clk);
      chk("early halt ack", 0, HOST.got.size());
      busy <= 1'b0;
      expect_rx({8'h06});
      chk("busy halt pulse", 2, n_halt);
      chk("button ignored", 0, n_pb);
      @(posedge clk) {jsucc, pbj} <= 2'b11;
      @(posedge clk) {jsucc, pbj} <= 2'b00;
      repeat (3) @(posedge clk);
      chk("button join", 1, n_pb);
      $display("Join test done");
      s = "\r\nConfiguration Reset\r\n";
      foreach (s[i])
         msg.push_back(s[i]);
      HOST.wr({8'h20, 8'haa, 8'hbb});
      expect_rx(msg);
      chk("defaults load", 1, n_load);
      chk("self reset", 1, n_rst);
      @(posedge clk) pbf <= 1'b1;
      @(posedge clk) pbf <= 1'b0;
      expect_rx(msg);
      chk("button defaults", 2, n_load);
      $display("Factory reset test done");
      complete_run();
   end
endmodule

/* test/lsc_host.sv */
// Host model sending escaped command frames and collecting answers
`timescale 1ns/1ns
module lsc_host
(
   input  wire        clk,
   output logic       rx_valid,
   output logic [7:0] rx_byte,
   input  wire        rx_ready,
   input  wire        tx_valid,
   input  wire [7:0]  tx_byte,
   output logic       tx_ready
);
   logic [7:0] got[$];
   initial
   begin
      rx_valid = 1'b0;
      rx_byte  = 8'h00;
      tx_ready = 1'b1;
   end
   always @(posedge clk)
   begin
      if (tx_valid && tx_ready)
         got.push_back(tx_byte);
      tx_ready <= ($urandom_range(3) != 0); // Random stall
   end
   task automatic put(input logic [7:0] b);
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_byte  <= b;
      do @(posedge clk); while (!rx_ready);
      rx_valid <= 1'b0;
      rx_byte  <= ~b; // Idle line shows no stale byte
   endtask
   task automatic send(input logic [7:0] q[$]);
      put(8'hff);
      put(8'(q.size()));
      foreach (q[i])
         put(q[i]);
   endtask
   task automatic wr(input logic [7:0] d[$]);
      logic [7:0] q[$];
      q = {8'hfe, 8'h47};
      foreach (d[i])
         if (d[i] >= 8'h80)
            q = {q, 8'hfe, 8'(d[i] - 8'h80)};
         else
            q.push_back(d[i]);
      send(q);
   endtask
endmodule
